// ### tb/spc_host_model.sv
/* master cpu model on the multiplexed bus
   fed the port's bus and wait enables */
`timescale 1ns/1ps
`default_nettype none
module spc_host_model
(
    input  wire logic       core_clk,
    input  wire logic [7:0] dut_out,
    input  wire logic [7:0] dut_oe,
    input  wire logic       wait_out,
    input  wire logic       wait_oe,
    output logic      [7:0] bus,
    output logic            as_n,
    output logic            ds_n,
    output logic            cs_n,
    output logic            rw
);
logic [7:0] drv = 8'h00;
logic       drv_en = 1'b0;
logic [7:0] last = 8'h00;
logic       saw_wait;
wire        wait_low = wait_oe && !wait_out;
// released bus toggles instead of holding a value
assign bus = (dut_oe == 8'hff) ? dut_out : drv_en ? drv : ~last;
always @(posedge core_clk) last <= bus;
initial
begin
    as_n = 1'b1;
    ds_n = 1'b1;
    cs_n = 1'b1;
    rw = 1'b1;
end
task automatic gap;
    repeat (8) @(posedge core_clk);
    #1;
endtask
task automatic cycle(input logic sel, input logic rd, input logic [7:0] a,
                     input logic [7:0] wd, output logic [7:0] rdat);
    saw_wait = 1'b0;
    cs_n = !sel;
    rw = rd;
    drv = a;
    drv_en = 1'b1;
    as_n = 1'b0;
    gap();
    as_n = 1'b1;
    gap();
    drv = wd;
    drv_en = !rd;
    gap();
    ds_n = 1'b0;
    for (int n = 0; n < 24 || (wait_low && n < 48); n++)
    begin
        @(posedge core_clk);
        #1;
        saw_wait = saw_wait | wait_low;
    end
    rdat = bus;
    ds_n = 1'b1;
    gap();
    drv_en = 1'b0;
    cs_n = 1'b1;
    gap();
endtask
task automatic sreset_on;
    as_n = 1'b0;
    ds_n = 1'b0;
    gap();
    as_n = 1'b1;
    gap();
endtask
task automatic sreset_off;
    ds_n = 1'b1;
    gap();
    gap();
endtask
endmodule // spc_host_model
`default_nettype wire

// ### tb/spc_host_port_properties.sv
/* pin checker for spc_host_port
   bound from tb onto every spc_host_port */
`timescale 1ns/1ps
`default_nettype none
module spc_host_port_properties
(
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       address_strobe_n,
    input wire logic       data_strobe_n,
    input wire logic       read_write,
    input wire logic [7:0] shared_bus_lines_oe,
    input wire logic       wait_n_out,
    input wire logic       wait_n_oe,
    input wire logic       slave_controller_reset,
    input wire logic       host_write_strobe,
    input wire logic       host_access_refused
);
// ****
// properties
// ****
default clocking cb @(posedge core_clk); endclocking
default disable iff (reset);
property p_wait_od; wait_n_out == 1'b0; endproperty
a_wait_od: assert property (p_wait_od) else $error("wait not open drain");
property p_rst;
    disable iff (1'b0) reset |=> slave_controller_reset && shared_bus_lines_oe == 8'h00;
endproperty
a_rst: assert property (p_rst) else $error("bad reset state");
property p_wait_len; $rose(wait_n_oe) |-> wait_n_oe[*2] ##1 !wait_n_oe; endproperty
a_wait_len: assert property (p_wait_len) else $error("wait length");
property p_oe_all; shared_bus_lines_oe == 8'h00 || shared_bus_lines_oe == 8'hff; endproperty
a_oe_all: assert property (p_oe_all) else $error("partial bus drive");
property p_oe_rel; $rose(data_strobe_n) |-> ##[0:6] shared_bus_lines_oe == 8'h00; endproperty
a_oe_rel: assert property (p_oe_rel) else $error("bus held after strobe");
property p_srst; (!address_strobe_n && !data_strobe_n)[*8] |-> slave_controller_reset; endproperty
a_srst: assert property (p_srst) else $error("no strobe reset");
property p_wait_ds; wait_n_oe |-> !data_strobe_n; endproperty
a_wait_ds: assert property (p_wait_ds) else $error("wait outside data phase");
property p_rd_dir; shared_bus_lines_oe != 8'h00 |-> read_write; endproperty
a_rd_dir: assert property (p_rd_dir) else $error("drive in write");
property p_wr_dir; host_write_strobe |-> !read_write && !$past(host_write_strobe); endproperty
a_wr_dir: assert property (p_wr_dir) else $error("bad write strobe");
property p_ref; host_access_refused |=> !host_access_refused; endproperty
a_ref: assert property (p_ref) else $error("refused not a pulse");
c_write: cover property (host_write_strobe);
c_refused: cover property (host_access_refused);
c_read: cover property (shared_bus_lines_oe == 8'hff);
c_srst: cover property (slave_controller_reset);
endmodule // spc_host_port_properties
`default_nettype wire

// ### tb/tb.sv
/* self-checking bench for spc_host_port
   host model on the bus, program port driven here */
`timescale 1ns/1ps
`default_nettype none
module tb;
logic core_clk = 1'b0, reset = 1'b1, core_we = 1'b0, host_access_enable = 1'b1;
logic [7:0] core_addr = 8'h00, core_wdata = 8'h00, bus, bus_out, bus_oe, core_rdata, reg_ptr, rd;
logic as_n, ds_n, cs_n, rw, wait_out, wait_oe, sc_reset, wr_stb, refused;
logic wr_seen = 1'b0, ref_seen = 1'b0;
int err_count = 0, cmp_count = 0;
logic [7:0] vis [5] = '{8'h00, 8'h04, 8'h05, 8'hf0, 8'hff};
logic [7:0] hid [5] = '{8'h01, 8'h03, 8'h06, 8'h10, 8'hef};
spc_host_port spc_host_port_i (.core_clk(core_clk), .reset(reset),
    .shared_bus_lines_in(bus), .shared_bus_lines_out(bus_out),
    .shared_bus_lines_oe(bus_oe), .address_strobe_n(as_n), .data_strobe_n(ds_n),
    .chip_select_n(cs_n), .read_write(rw), .wait_n_out(wait_out), .wait_n_oe(wait_oe),
    .host_access_enable(host_access_enable), .core_we(core_we), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata), .reg_ptr(reg_ptr),
    .slave_controller_reset(sc_reset), .host_write_strobe(wr_stb),
    .host_access_refused(refused));
spc_host_model spc_host_model_i (.core_clk(core_clk), .dut_out(bus_out), .dut_oe(bus_oe),
    .wait_out(wait_out), .wait_oe(wait_oe), .bus(bus), .as_n(as_n), .ds_n(ds_n),
    .cs_n(cs_n), .rw(rw));
initial forever #2.5 core_clk = ~core_clk;
always @(posedge core_clk) if (wr_stb) wr_seen <= 1'b1;
always @(posedge core_clk) if (refused) ref_seen <= 1'b1;
task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
        err_count++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task automatic hop(input logic sel, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr_seen = 1'b0;
    ref_seen = 1'b0;
    spc_host_model_i.cycle(sel, r, a, d, rd);
endtask
task automatic cw(input logic [7:0] a, input logic [7:0] d);
    core_we = 1'b1;
    core_addr = a;
    core_wdata = d;
    @(posedge core_clk);
    #1;
    core_we = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
endtask
// ****
// scenarios
// ****
task automatic t_visible;
    foreach (vis[i])
    begin
        hop(1'b1, 1'b0, vis[i], vis[i] ^ 8'h5a);
        check(8'(wr_seen), 8'h01);
        check(8'(spc_host_model_i.saw_wait), 8'h01);
        hop(1'b1, 1'b1, vis[i], 8'h00);
        check(rd, vis[i] ^ 8'h5a);
    end
endtask
task automatic t_hidden;
    foreach (hid[i])
    begin
        cw(hid[i], 8'h33);
        hop(1'b1, 1'b0, hid[i], 8'hcc);
        check(8'(ref_seen), 8'h01);
        hop(1'b1, 1'b1, hid[i], 8'h00);
        check(rd, 8'h00);
        core_addr = hid[i];
        repeat (2) @(posedge core_clk);
        #1;
        check(core_rdata, 8'h33);
    end
endtask
task automatic t_disable;
    hop(1'b1, 1'b0, 8'hf1, 8'h11);
    host_access_enable = 1'b0;
    hop(1'b1, 1'b0, 8'hf1, 8'h22);
    check(8'(ref_seen), 8'h01);
    hop(1'b1, 1'b1, 8'hf1, 8'h00);
    check(rd, 8'h00);
    host_access_enable = 1'b1;
    hop(1'b1, 1'b1, 8'hf1, 8'h00);
    check(rd, 8'h11);
endtask
task automatic t_no_cs;
    cw(8'hf2, 8'h44);
    hop(1'b0, 1'b0, 8'hf2, 8'h99);
    check(8'(wr_seen), 8'h00);
    check(8'(spc_host_model_i.saw_wait), 8'h00);
    hop(1'b1, 1'b1, 8'hf2, 8'h00);
    check(rd, 8'h44);
endtask
task automatic t_ptr;
    hop(1'b1, 1'b0, 8'hfd, 8'ha0);
    check(reg_ptr, 8'ha0);
    cw(8'hfd, 8'h30);
    check(reg_ptr, 8'h30);
    hop(1'b1, 1'b0, 8'hf3, 8'hc3);
    core_addr = 8'hf3;
    repeat (2) @(posedge core_clk);
    #1;
    check(core_rdata, 8'hc3);
endtask
task automatic t_sreset;
    spc_host_model_i.sreset_on();
    check(8'(sc_reset), 8'h01);
    spc_host_model_i.sreset_off();
    check(8'(sc_reset), 8'h00);
endtask
task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
initial
begin
    repeat (2) @(posedge core_clk);
    #1;
    check(8'(sc_reset), 8'h01);
    check(bus_oe, 8'h00);
    check(8'(wait_oe), 8'h00);
    reset = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    t_visible();
    t_hidden();
    t_disable();
    t_no_cs();
    t_ptr();
    t_sreset();
    tally_and_finish();
end
initial
begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
end
endmodule // tb
bind spc_host_port spc_host_port_properties spc_host_port_properties_i (.core_clk(core_clk),
    .reset(reset), .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
    .read_write(read_write), .shared_bus_lines_oe(shared_bus_lines_oe),
    .wait_n_out(wait_n_out), .wait_n_oe(wait_n_oe),
    .slave_controller_reset(slave_controller_reset),
    .host_write_strobe(host_write_strobe), .host_access_refused(host_access_refused));
`default_nettype wire

// ### verilog/spc_host_port.sv
/*
 * spc_host_port: multiplexed 8-bit host bus port of a slave controller.
 * Holds the bus state machine, wait generation and the internal program port.
 * A combined strobe reset holds the bus logic idle while data strobe is low.
 * Wait is fixed at two core cycles because the register file answers in one.
 * Assumes host pins are asynchronous to core_clk and bus levels are resolved
 * by the surrounding wiring from the output enables.
 */
// Functional notes
// R1: address and data share eight bus lines
// R2: host frames cycle with address strobe rise
// R3: act only if chip select low at rise
// R4: read/write high reads, low writes
// R5: data strobe times the data movement
// R6: both strobes low resets while data strobe low
// R7: wait held low until access completes
// R8: bus pins synchronised into core clock
// R9: 256-byte file shared by host and program
// R10: host reaches only 19 interface registers directly
// R11: program enables or blocks host access
// R12: sixteen groups selected by register pointer
// R13: interface registers at 00, 04, 05, f0-ff
// R14: address latched on address strobe rise
// R15: release wait, then bus after data strobe
`timescale 1ns/1ps
`default_nettype none
module spc_host_port
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [7:0] shared_bus_lines_in,
    output logic      [7:0] shared_bus_lines_out,
    output logic      [7:0] shared_bus_lines_oe,
    input  wire logic       address_strobe_n,
    input  wire logic       data_strobe_n,
    input  wire logic       chip_select_n,
    input  wire logic       read_write,
    output logic            wait_n_out,
    output logic            wait_n_oe,
    input  wire logic       host_access_enable,
    input  wire logic       core_we,
    input  wire logic [7:0] core_addr,
    input  wire logic [7:0] core_wdata,
    output logic      [7:0] core_rdata,
    output logic      [7:0] reg_ptr,
    output logic            slave_controller_reset,
    output logic            host_write_strobe,
    output logic            host_access_refused
);
    //****************************************
    // synchronisers
    //****************************************
    logic [7:0] bus_s;
    logic [3:0] ctl_s;
    logic       as_n;
    logic       ds_n;
    logic       cs_n;
    logic       rw;
    logic       as_n_d;

    spc_pin_sync #(.WIDTH(8), .INIT(8'h00)) u_bus_sync
    (
        .core_clk (core_clk),
        .reset    (reset),
        .pin      (shared_bus_lines_in),
        .level    (bus_s)
    ); // R8
    spc_pin_sync #(.WIDTH(4), .INIT(4'hf)) u_ctl_sync
    (
        .core_clk (core_clk),
        .reset    (reset),
        .pin      ({address_strobe_n, data_strobe_n, chip_select_n, read_write}),
        .level    (ctl_s)
    ); // R8

    assign as_n = ctl_s[3];
    assign ds_n = ctl_s[2];
    assign cs_n = ctl_s[1];
    assign rw   = ctl_s[0];

    //****************************************
    // decode
    //****************************************
    spc_rf_if rf();

    spc_reg_file u_reg_file
    (
        .core_clk (core_clk),
        .reset    (reset),
        .rf       (rf.store)
    ); // R9

    spc_pkg::spc_state_t state;
    spc_pkg::spc_state_t next_state;
    logic [7:0] addr;
    logic       is_read;
    logic       selected;
    logic       as_rise;
    logic       strobe_reset;
    logic       addr_ok;
    logic       do_write;
    logic       ds_rise;
    logic       ds_n_d;
    logic [7:0] next_bus_out;
    logic [7:0] next_addr;
    logic       next_is_read;
    logic       next_selected;
    logic       next_wait_oe;
    logic       next_refused;
    logic       drive_read;
    logic       sreset_hold;
    logic       next_sreset_hold;
    logic       sreset_now;
    logic       bus_reset;

    //****************************************
    // strobe decode
    //****************************************
    assign as_rise          = as_n && !as_n_d;
    assign ds_rise          = ds_n && !ds_n_d;
    assign strobe_reset     = !as_n && !ds_n; // R6
    // once entered, strobe reset lasts until data strobe rises
    assign sreset_now       = strobe_reset || (sreset_hold && !ds_n); // R6
    assign next_sreset_hold = sreset_now;
    assign bus_reset        = reset || sreset_now;

    //****************************************
    // access decode
    //****************************************
    // refused pulse marks a selected access to a hidden or blocked location
    assign addr_ok       = spc_pkg::spc_host_visible(addr) && host_access_enable; // R10 R11 R13
    assign do_write      = (state == spc_pkg::SPC_ACCESS) && !is_read && addr_ok; // R4
    assign next_addr     = as_rise ? bus_s : addr; // R14
    assign next_is_read  = as_rise ? rw : is_read; // R4
    assign next_selected = as_rise ? !cs_n : selected; // R3
    assign next_wait_oe  = (next_state == spc_pkg::SPC_ACCESS)
                           || (next_state == spc_pkg::SPC_ADDR); // R7
    assign next_refused  = (state == spc_pkg::SPC_ACCESS) && !addr_ok;
    assign drive_read    = (state == spc_pkg::SPC_ADDR) && is_read && selected; // R1

    //****************************************
    // register file port
    //****************************************
    assign rf.host_we    = do_write;
    assign rf.host_addr  = addr;
    assign rf.host_wdata = bus_s; // R1
    assign rf.core_we    = core_we;
    assign rf.core_addr  = core_addr;
    assign rf.core_wdata = core_wdata;
    assign next_bus_out  = addr_ok ? rf.host_rdata : spc_pkg::RESET_DATA;

    //****************************************
    // bus state machine
    //****************************************
    always_comb
    begin
        next_state = state;
        case (state)
            spc_pkg::SPC_IDLE:
                if (as_rise && !cs_n)
                    next_state = spc_pkg::SPC_WAIT_DS; // R2 R3
            spc_pkg::SPC_WAIT_DS:
                if (!ds_n)
                    next_state = spc_pkg::SPC_ACCESS; // R5
                else if (as_rise)
                    next_state = cs_n ? spc_pkg::SPC_IDLE : spc_pkg::SPC_WAIT_DS;
            spc_pkg::SPC_ACCESS:
                next_state = spc_pkg::SPC_ADDR;
            spc_pkg::SPC_ADDR:
                next_state = spc_pkg::SPC_DONE;
            spc_pkg::SPC_DONE:
                if (ds_rise || ds_n)
                    next_state = spc_pkg::SPC_IDLE; // R15
            default:
                next_state = spc_pkg::SPC_IDLE;
        endcase
    end

    //****************************************
    // bus state and strobe history
    //****************************************
    always_ff @(posedge core_clk)
    begin
        if (bus_reset)
            state <= spc_pkg::SPC_IDLE;
        else
            state <= next_state;
    end

    // history resets to the idle level so no false edge follows a reset
    always_ff @(posedge core_clk)
    begin
        if (bus_reset)
        begin
            as_n_d <= 1'b1;
            ds_n_d <= 1'b1;
        end
        else
        begin
            as_n_d <= as_n;
            ds_n_d <= ds_n;
        end
    end

    //****************************************
    // transaction capture
    //****************************************
    // address and direction are taken only on the address strobe rise
    always_ff @(posedge core_clk)
    begin
        if (bus_reset)
        begin
            addr     <= spc_pkg::RESET_DATA;
            is_read  <= 1'b0;
            selected <= 1'b0;
        end
        else
        begin
            addr     <= next_addr; // R14
            is_read  <= next_is_read; // R4
            selected <= next_selected; // R3
        end
    end

    // hold host from strobe until our side finishes
    always_ff @(posedge core_clk)
    begin
        if (bus_reset)
            wait_n_oe <= 1'b0;
        else
            wait_n_oe <= next_wait_oe; // R7 R15
    end

    // one-cycle pulse as a host write lands
    always_ff @(posedge core_clk)
    begin
        if (bus_reset)
            host_write_strobe <= 1'b0;
        else
            host_write_strobe <= do_write;
    end

    always_ff @(posedge core_clk)
    begin
        if (bus_reset)
            host_access_refused <= 1'b0;
        else
            host_access_refused <= next_refused; // R11
    end

    //****************************************
    // read data drive
    //****************************************
    // drive read data until data strobe is seen high
    always_ff @(posedge core_clk)
    begin
        if (bus_reset)
        begin
            shared_bus_lines_out <= spc_pkg::RESET_DATA;
            shared_bus_lines_oe  <= 8'h00;
        end
        else if (drive_read)
        begin
            shared_bus_lines_out <= next_bus_out; // R1
            shared_bus_lines_oe  <= 8'hff;
        end
        else if (ds_n)
        begin
            shared_bus_lines_oe  <= 8'h00; // R15
        end
    end

    //****************************************
    // reset status and program port
    //****************************************
    // wait is open drain: the pin level is fixed low, only its enable moves
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            sreset_hold            <= 1'b0;
            slave_controller_reset <= 1'b1;
            wait_n_out             <= 1'b0;
        end
        else
        begin
            sreset_hold            <= next_sreset_hold;
            slave_controller_reset <= sreset_now; // R6
            wait_n_out             <= 1'b0;
        end
    end

    // program read data and pointer, registered for the pins
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            core_rdata <= spc_pkg::RESET_DATA;
            reg_ptr    <= spc_pkg::RESET_REG_PTR;
        end
        else
        begin
            core_rdata <= rf.core_rdata;
            reg_ptr    <= rf.reg_ptr; // R12
        end
    end
endmodule // spc_host_port
`default_nettype wire

// ### verilog/spc_pin_sync.sv
/*
 * spc_pin_sync: three-stage synchroniser with agreement filter.
 * Assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module spc_pin_sync
#(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
)
(
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] next_level;

    assign agree      = ~(stage2 ^ stage3);
    assign next_level = (agree & stage3) | (~agree & level);

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            level  <= INIT;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end
endmodule // spc_pin_sync
`default_nettype wire

// ### verilog/spc_pkg.sv
/*
 * spc_pkg: constants and types for the slave controller host bus port.
 * Assumes a single core_clk domain; host bus pins are asynchronous to it.
 */
package spc_pkg;
    localparam int          REG_FILE_DEPTH   = 256;
    localparam int          GROUP_SIZE       = 16;
    localparam int          HOST_REG_COUNT   = 19;
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_PORT_LO     = 8'h01;
    localparam logic [7:0]  ADDR_PORT_HI     = 8'h03;
    localparam logic [7:0]  ADDR_LIMIT       = 8'h04;
    localparam logic [7:0]  ADDR_INDIR       = 8'h05;
    localparam logic [7:0]  ADDR_HIGH_BASE   = 8'hf0;
    localparam logic [7:0]  ADDR_REG_PTR     = 8'hfd;
    localparam logic [7:0]  RESET_REG_PTR    = 8'h00;
    localparam logic [7:0]  RESET_DATA       = 8'h00;
    localparam int          SYNC_STAGES      = 3;
    localparam int          CORE_CLK_MHZ     = 200;
    localparam int          MIN_HOLD_NS      = 10;
    localparam int          MIN_HOLD_CYCLES  = (MIN_HOLD_NS * CORE_CLK_MHZ + 999) / 1000;

    typedef enum {
        SPC_IDLE,
        SPC_ADDR,
        SPC_WAIT_DS,
        SPC_ACCESS,
        SPC_DONE
    } spc_state_t;

    // true for the 19 locations the host may address directly
    function automatic logic spc_host_visible(input logic [7:0] addr);
        spc_host_visible = (addr == ADDR_CTRL) || (addr == ADDR_LIMIT)
            || (addr == ADDR_INDIR) || (addr >= ADDR_HIGH_BASE);
    endfunction
endpackage

// ### verilog/spc_reg_file.sv
/*
 * spc_reg_file: 256-byte register file, 16 groups of 16 working registers.
 * Assumes the core side wins a same-cycle write collision.
 */
`timescale 1ns/1ps
`default_nettype none
module spc_reg_file
#(
    parameter int DEPTH = spc_pkg::REG_FILE_DEPTH
)
(
    input  wire logic core_clk,
    input  wire logic reset,
    spc_rf_if.store   rf
);
    logic [7:0] mem [DEPTH];
    logic [7:0] reg_ptr;
    logic       ptr_from_core;
    logic       ptr_from_host;

    assign ptr_from_core = rf.core_we && (rf.core_addr == spc_pkg::ADDR_REG_PTR);
    assign ptr_from_host = rf.host_we && (rf.host_addr == spc_pkg::ADDR_REG_PTR);
    assign rf.reg_ptr    = reg_ptr;

    always_ff @(posedge core_clk)
    begin
        if (rf.host_we && !(rf.core_we && rf.core_addr == rf.host_addr))
            mem[rf.host_addr] <= rf.host_wdata;
        if (rf.core_we)
            mem[rf.core_addr] <= rf.core_wdata;
        rf.host_rdata <= mem[rf.host_addr];
        rf.core_rdata <= mem[rf.core_addr];
    end

    // pointer copy kept for short-format group selection
    always_ff @(posedge core_clk)
    begin
        if (reset)
            reg_ptr <= spc_pkg::RESET_REG_PTR;
        else if (ptr_from_core)
            reg_ptr <= rf.core_wdata; // R12
        else if (ptr_from_host)
            reg_ptr <= rf.host_wdata;
    end
endmodule // spc_reg_file
`default_nettype wire

// ### verilog/spc_rf_if.sv
/*
 * spc_rf_if: register file access channel between bus port and storage.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface spc_rf_if;
    logic       host_we;
    logic [7:0] host_addr;
    logic [7:0] host_wdata;
    logic [7:0] host_rdata;
    logic       core_we;
    logic [7:0] core_addr;
    logic [7:0] core_wdata;
    logic [7:0] core_rdata;
    logic [7:0] reg_ptr;

    modport port
    (
        output host_we,
        output host_addr,
        output host_wdata,
        input  host_rdata,
        output core_we,
        output core_addr,
        output core_wdata,
        input  core_rdata,
        input  reg_ptr
    );
    modport store
    (
        input  host_we,
        input  host_addr,
        input  host_wdata,
        output host_rdata,
        input  core_we,
        input  core_addr,
        input  core_wdata,
        output core_rdata,
        output reg_ptr
    );
endinterface
`default_nettype wire
